// ---- logic/tmrps_top.sv ----
/*
 * tmrps_top: 8-bit timer/counter with shared prescaler, overflow flag,
 * register port and a level interrupt.
 * Assumes i_clk is the instruction-cycle clock and software on the port
 * never reads and writes in the same cycle.
 */
// The implementer's own choice: the strobed register port.
// How it works
// - the counter wraps from ff to 00 and each wrap sets the overflow flag.
// - a cleared clock source select runs the counter from the internal clock.
// - in timer mode without prescaler the counter steps every cycle.
// - a software write to the counter blocks increments for two cycles.
// - a set clock source select counts edges of the external pin instead.
// - the edge select bit picks rising when clear and falling when set.
// - one prescaler serves either this counter or the watchdog, never both.
// - assignment bit clear routes the prescaler here, set to the watchdog.
// - the prescaler count cannot be read or written by software.
// - assigned here the prescaler divides by 2 up to 256 in powers of two.
// - the overflow interrupt is raised only while the enable bit is set.
// - in sleep the counter is halted and makes no overflow.
`timescale 1ns/1ps
`default_nettype none
module tmrps_top (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // external count pin and sleep
    input wire logic i_ext_count_pin,
    input wire logic i_sleep,
    // watchdog side of the prescaler
    input wire logic i_wdt_tick,
    output logic o_wdt_scaled,
    // interrupt
    output logic o_irq,
    output logic o_ovf_irq
);
    tmrps_pkg::tmrps_req_type req;
    tmrps_pkg::tmrps_opt_type opt;
    tmrps_pkg::tmrps_state_type state_q, state_d;
    logic [7:0] count_q, count_d;
    logic [7:0] option_q;
    logic ovf_en_q;
    logic ovf_flag_q, ovf_flag_d;
    logic stat_q, stat_d;
    logic en_q;
    logic sleep_q;
    logic [7:0] ps_q, ps_d;
    logic [7:0] rdata_q, rdata_d;
    logic irq_q;
    logic ovf_irq_q;
    logic wdt_scaled_q;
    logic ext_pulse;

    assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
    assign opt = '{clk_src: option_q[tmrps_pkg::OPT_CS_BIT],
                   edge_fall: option_q[tmrps_pkg::OPT_SE_BIT],
                   psa_wdt: option_q[tmrps_pkg::OPT_PSA_BIT],
                   ps_sel: option_q[tmrps_pkg::OPT_PS_LSB +: tmrps_pkg::OPT_PS_W]};

    tmrps_edge u_edge (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_pin(i_ext_count_pin),
        .i_fall(opt.edge_fall),
        .o_pulse(ext_pulse)
    );

    // address decode
    wire wr_count = req.wr && req.addr == tmrps_pkg::ADDR_COUNT;
    wire wr_option = req.wr && req.addr == tmrps_pkg::ADDR_OPTION;
    wire wr_intctl = req.wr && req.addr == tmrps_pkg::ADDR_INTCTL;
    wire wr_irq_en = req.wr && req.addr == tmrps_pkg::ADDR_IRQ_EN;
    wire wr_irq_clr = req.wr && req.addr == tmrps_pkg::ADDR_IRQ_CLR;
    wire wr_sleep = req.wr && req.addr == tmrps_pkg::ADDR_SLEEP;
    wire asleep = i_sleep | sleep_q;

    // tick source: internal cycle or synchronised pin edge
    wire src_tick = opt.clk_src ? ext_pulse : 1'b1;
    // prescaler is shared; only one consumer sees it
    wire ps_to_tmr = ~opt.psa_wdt;
    wire ps_in = ps_to_tmr ? (src_tick & ~asleep) : i_wdt_tick;
    wire [7:0] ps_inc = ps_q + 8'h01;
    // divide-by-2^(sel+1): output when bit sel of the count steps from 0 to 1
    wire ps_out = ps_in && (ps_inc[opt.ps_sel] & ~ps_q[opt.ps_sel]);
    wire hold = state_q != tmrps_pkg::TMRPS_RUN;
    wire tmr_tick = (ps_to_tmr ? ps_out : src_tick) & ~asleep & ~hold;
    wire wrap = tmr_tick && count_q == tmrps_pkg::COUNT_MAX;
    wire flag_clr_w = wr_intctl && !req.wdata[tmrps_pkg::INT_OVF_FLAG_BIT];
    wire flag_set_w = wr_intctl && req.wdata[tmrps_pkg::INT_OVF_FLAG_BIT];

    // count register and prescaler
    always_comb begin
        count_d = count_q;
        ps_d = ps_q;
        if (ps_in) begin
            ps_d = ps_inc;
        end
        if (wr_count) begin
            count_d = req.wdata;
            ps_d = 8'h00; // prescaler restarts on a counter write
        end else if (tmr_tick) begin
            count_d = count_q + 8'h01;
        end
        if (wr_option) begin
            ps_d = 8'h00; // reassignment would otherwise leak a stale count
        end
    end

    // write hold sequence
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            tmrps_pkg::TMRPS_RUN: state_d = tmrps_pkg::TMRPS_RUN;
            tmrps_pkg::TMRPS_HOLD1: state_d = tmrps_pkg::TMRPS_HOLD2;
            tmrps_pkg::TMRPS_HOLD2: state_d = tmrps_pkg::TMRPS_RUN;
            default: state_d = tmrps_pkg::TMRPS_RUN;
        endcase
        if (wr_count) begin
            state_d = tmrps_pkg::TMRPS_HOLD1;
        end
    end

    // set wins over clear; hardware never clears the flag
    always_comb begin
        ovf_flag_d = ovf_flag_q;
        if (flag_clr_w) begin
            ovf_flag_d = 1'b0;
        end
        if (flag_set_w || wrap) begin
            ovf_flag_d = 1'b1;
        end
        stat_d = stat_q;
        if (wr_irq_clr && req.wdata[tmrps_pkg::EV_OVF_BIT]) begin
            stat_d = 1'b0;
        end
        if (wrap) begin
            stat_d = 1'b1;
        end
    end

    // read mux; prescaler count is deliberately absent
    always_comb begin
        rdata_d = 8'h00;
        unique case (req.addr)
            tmrps_pkg::ADDR_COUNT: rdata_d = count_q;
            tmrps_pkg::ADDR_OPTION: rdata_d = option_q;
            tmrps_pkg::ADDR_INTCTL: begin
                rdata_d[tmrps_pkg::INT_OVF_EN_BIT] = ovf_en_q;
                rdata_d[tmrps_pkg::INT_OVF_FLAG_BIT] = ovf_flag_q;
            end
            tmrps_pkg::ADDR_IRQ_STAT: rdata_d[tmrps_pkg::EV_OVF_BIT] = stat_q;
            tmrps_pkg::ADDR_IRQ_EN: rdata_d[tmrps_pkg::EV_OVF_BIT] = en_q;
            tmrps_pkg::ADDR_SLEEP: rdata_d[0] = sleep_q;
            default: rdata_d = 8'h00;
        endcase
        if (!req.rd) begin
            rdata_d = 8'h00;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            count_q <= tmrps_pkg::COUNT_RST;
            ps_q <= 8'h00;
            state_q <= tmrps_pkg::TMRPS_RUN;
            ovf_flag_q <= 1'b0;
            stat_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            count_q <= count_d;
            ps_q <= ps_d;
            state_q <= state_d;
            ovf_flag_q <= ovf_flag_d;
            stat_q <= stat_d;
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            option_q <= tmrps_pkg::OPTION_RST;
            ovf_en_q <= tmrps_pkg::INTCTL_RST[tmrps_pkg::INT_OVF_EN_BIT];
            en_q <= 1'b0;
            sleep_q <= 1'b0;
        end else begin
            if (wr_option) option_q <= req.wdata;
            if (wr_intctl) ovf_en_q <= req.wdata[tmrps_pkg::INT_OVF_EN_BIT];
            if (wr_irq_en) en_q <= req.wdata[tmrps_pkg::EV_OVF_BIT];
            if (wr_sleep) sleep_q <= req.wdata[0];
        end
    end

    // registered outputs
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            irq_q <= 1'b0;
            ovf_irq_q <= 1'b0;
            wdt_scaled_q <= 1'b0;
        end else begin
            irq_q <= stat_d & en_q;
            ovf_irq_q <= ovf_flag_d & ovf_en_q;
            wdt_scaled_q <= opt.psa_wdt ? ps_out : i_wdt_tick;
        end
    end

    assign o_rdata = rdata_q;
    assign o_irq = irq_q;
    assign o_ovf_irq = ovf_irq_q;
    assign o_wdt_scaled = wdt_scaled_q;

    a_count_wrap: assert property (@(posedge i_clk) disable iff (i_rst)
        wrap && !wr_count |=> count_q == 8'h00 && ovf_flag_q)
        else $error("wrap did not zero count and set flag");
    a_write_hold: assert property (@(posedge i_clk) disable iff (i_rst)
        wr_count ##1 !wr_count [*2] |-> $stable(count_q))
        else $error("count moved during write hold");
    a_timer_step: assert property (@(posedge i_clk) disable iff (i_rst)
        !opt.clk_src && opt.psa_wdt && !asleep && !hold && !wr_count && !wr_option
        |=> count_q == $past(count_q) + 8'h01)
        else $error("timer mode did not step");
    a_ext_edge: assert property (@(posedge i_clk) disable iff (i_rst)
        opt.clk_src && opt.psa_wdt && !ext_pulse && !wr_count |=> $stable(count_q))
        else $error("counter mode stepped without edge");
    a_sleep_halt: assert property (@(posedge i_clk) disable iff (i_rst)
        asleep && !wr_count |=> $stable(count_q))
        else $error("count moved in sleep");
    a_flag_kept: assert property (@(posedge i_clk) disable iff (i_rst)
        ovf_flag_q && !wr_intctl |=> ovf_flag_q)
        else $error("flag cleared without software");
    a_irq_mask: assert property (@(posedge i_clk) disable iff (i_rst)
        ##1 o_ovf_irq |-> $past(ovf_en_q) && ovf_flag_q)
        else $error("irq raised while masked");
    a_ps_route: assert property (@(posedge i_clk) disable iff (i_rst)
        opt.psa_wdt && !i_wdt_tick |-> ps_q == $past(ps_q) || $past(wr_count)
        || $past(wr_option) || $past(i_wdt_tick))
        else $error("prescaler moved without watchdog tick");
    // at ratio 2 a tick may only leave on the even count, i.e. every other cycle
    a_ps_div2: assert property (@(posedge i_clk) disable iff (i_rst)
        ps_to_tmr && opt.ps_sel == 3'h0 && tmr_tick |-> ps_q[0] == 1'b0)
        else $error("divide-by-two ratio wrong");
    a_edge_step: assert property (@(posedge i_clk) disable iff (i_rst)
        opt.clk_src && opt.psa_wdt && ext_pulse && !hold && !asleep && !wr_count
        && !wr_option |=> count_q == $past(count_q) + 8'h01)
        else $error("counter mode edge did not step once");
    c_wrap: cover property (@(posedge i_clk) wrap);
    c_ext_tick: cover property (@(posedge i_clk) opt.clk_src && tmr_tick);
    c_hold: cover property (@(posedge i_clk) wr_count ##3 tmr_tick);
    c_irq: cover property (@(posedge i_clk) o_ovf_irq);
endmodule
`default_nettype wire

// ---- logic/tmrps_pkg.sv ----
/*
 * tmrps_pkg: register map, field positions, reset values and shared types
 * of the 8-bit timer/counter with shared prescaler.
 * Assumes a byte-wide register port with one-cycle read latency.
 */
package tmrps_pkg;
    // register addresses
    localparam logic [7:0] ADDR_COUNT = 8'h01;
    localparam logic [7:0] ADDR_OPTION = 8'h81;
    localparam logic [7:0] ADDR_INTCTL = 8'h0b;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h20;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h21;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h22;
    localparam logic [7:0] ADDR_SLEEP = 8'h23;
    // option register fields
    localparam int OPT_CS_BIT = 5;
    localparam int OPT_SE_BIT = 4;
    localparam int OPT_PSA_BIT = 3;
    localparam int OPT_PS_LSB = 0;
    localparam int OPT_PS_W = 3;
    // interrupt control fields
    localparam int INT_OVF_EN_BIT = 5;
    localparam int INT_OVF_FLAG_BIT = 2;
    // reset values and the counter maximum
    localparam logic [7:0] OPTION_RST = 8'hff;
    localparam logic [7:0] INTCTL_RST = 8'h00;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hff;
    // increment suppression after a write, in cycles
    localparam logic [1:0] WR_HOLD_CYC = 2'h2;
    // status/enable bit of the overflow event
    localparam int EV_OVF_BIT = 0;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tmrps_req_type;

    typedef struct packed {
        logic clk_src;
        logic edge_fall;
        logic psa_wdt;
        logic [2:0] ps_sel;
    } tmrps_opt_type;

    typedef enum logic [1:0] {
        TMRPS_RUN = 2'b00,
        TMRPS_HOLD1 = 2'b01,
        TMRPS_HOLD2 = 2'b11
    } tmrps_state_type;
endpackage

// ---- logic/tmrps_edge.sv ----
/*
 * tmrps_edge: two-flop synchroniser and selectable edge detector for the
 * external count input. One pulse per qualifying edge.
 * Assumes the pin is slower than half the clock rate.
 */
`timescale 1ns/1ps
`default_nettype none
module tmrps_edge (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // pin and edge choice
    input wire logic i_pin,
    input wire logic i_fall,
    // one-cycle edge pulse
    output logic o_pulse
);
    logic meta_q;
    logic sync_q;
    logic last_q;
    logic pulse_q;
    wire rise_w = sync_q & ~last_q;
    wire fall_w = ~sync_q & last_q;
    wire pulse_d = i_fall ? fall_w : rise_w;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
            pulse_q <= 1'b0;
        end else begin
            meta_q <= i_pin;
            sync_q <= meta_q;
            last_q <= sync_q;
            pulse_q <= pulse_d;
        end
    end
    assign o_pulse = pulse_q;
endmodule
`default_nettype wire

// ---- test/tmrps_pin_src.sv ----
/*
 * tmrps_pin_src: external count source for the count pin.
 * Assumes the bench raises i_go for one cycle and then waits on o_busy.
 */
`timescale 1ns/1ps
`default_nettype none
module tmrps_pin_src (
    // command from the bench
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic [7:0] i_toggles,
    input wire logic [7:0] i_half_ns,
    // pin side
    output logic o_pin,
    output logic o_busy
);
    initial begin
        o_pin = 1'b0;
        o_busy = 1'b0;
        forever begin
            @(posedge i_clk iff i_go);
            o_busy = 1'b1;
            // odd offset keeps pin edges off rising clock edges, except the first toggle at half 8'h1b (3 + 27 ns)
            #3;
            repeat (i_toggles) begin
                #(i_half_ns);
                // each level lasts several clocks so the sampler sees it
                o_pin = ~o_pin;
            end
            #(i_half_ns);
            o_busy = 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- test/tb.sv ----
/*
 * tb: register-port bench of the timer/counter with the count pin model.
 * Assumes a 100 MHz clock and the register map of the package.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic i_clk, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_sleep = 1'b0, i_wdt_tick = 1'b0;
    logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata, rd_v, toggles = 8'h00, half = 8'h00;
    logic o_wdt_scaled, o_irq, o_ovf_irq, pin, go = 1'b0, busy;
    int error_cnt = 0, num_checks = 0, wdt_cnt = 0;
    logic [7:0] reg_a [7] = '{tmrps_pkg::ADDR_COUNT, tmrps_pkg::ADDR_OPTION,
        tmrps_pkg::ADDR_INTCTL, tmrps_pkg::ADDR_IRQ_STAT, tmrps_pkg::ADDR_IRQ_EN,
        tmrps_pkg::ADDR_IRQ_CLR, 8'h55};
    logic [7:0] reg_v [7] = '{tmrps_pkg::COUNT_RST, tmrps_pkg::OPTION_RST,
        tmrps_pkg::INTCTL_RST, 8'h00, 8'h00, 8'h00, 8'h00};

    tmrps_top i_tmrps_top (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_ext_count_pin(pin), .i_sleep(i_sleep), .i_wdt_tick(i_wdt_tick),
        .o_wdt_scaled(o_wdt_scaled), .o_irq(o_irq), .o_ovf_irq(o_ovf_irq));
    tmrps_pin_src i_tmrps_pin_src (.i_clk(i_clk), .i_go(go), .i_toggles(toggles),
        .i_half_ns(half), .o_pin(pin), .o_busy(busy));

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    always @(posedge i_clk) if (o_wdt_scaled === 1'b1) wdt_cnt++;

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // wr and rd start and end 1 ns after a rising edge; burst returns on the edge itself
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        #1 i_wr <= 1'b0;
        @(posedge i_clk);
        #1;
    endtask

    task automatic rd(input logic [7:0] a);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        #1 i_rd <= 1'b0;
        rd_v = o_rdata;
        @(posedge i_clk);
        #1;
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic burst(input logic [7:0] n, input logic [7:0] h);
        toggles <= n;
        half <= h;
        go <= 1'b1;
        @(posedge i_clk);
        #1 go <= 1'b0;
        for (int k = 0; k < 200; k++) begin
            @(posedge i_clk);
            if (busy === 1'b0) return;
        end
        error_cnt++;
        stop_test();
    endtask

    initial begin
        repeat (20) @(posedge i_clk);
        #1 i_rst <= 1'b0;
        foreach (reg_a[k]) begin
            rd(reg_a[k]);
            chk(rd_v, reg_v[k]);
        end
        $display("test done: reset values");
        // timer mode, prescaler on the watchdog side, write near the wrap
        wr(tmrps_pkg::ADDR_OPTION, 8'h08);
        wr(tmrps_pkg::ADDR_COUNT, 8'hfe);
        rd(tmrps_pkg::ADDR_COUNT);
        chk(rd_v, 8'hfe);
        rd(tmrps_pkg::ADDR_COUNT);
        chk(rd_v, 8'hff);
        rd(tmrps_pkg::ADDR_COUNT);
        chk(rd_v, 8'h01);
        rd(tmrps_pkg::ADDR_INTCTL);
        chk(rd_v, 8'h04);
        chk({7'h00, o_ovf_irq}, 8'h00);
        $display("test done: timer wrap");
        i_sleep <= 1'b1;
        wr(tmrps_pkg::ADDR_COUNT, 8'h80);
        repeat (8) @(posedge i_clk);
        #1 rd(tmrps_pkg::ADDR_COUNT);
        chk(rd_v, 8'h80);
        $display("test done: sleep");
        rd(tmrps_pkg::ADDR_IRQ_STAT);
        chk(rd_v, 8'h01);
        chk({7'h00, o_irq}, 8'h00);
        wr(tmrps_pkg::ADDR_INTCTL, 8'h24);
        chk({7'h00, o_ovf_irq}, 8'h01);
        rd(tmrps_pkg::ADDR_INTCTL);
        chk(rd_v, 8'h24);
        wr(tmrps_pkg::ADDR_INTCTL, 8'h20);
        chk({7'h00, o_ovf_irq}, 8'h00);
        wr(tmrps_pkg::ADDR_IRQ_EN, 8'h01);
        chk({7'h00, o_irq}, 8'h01);
        wr(tmrps_pkg::ADDR_IRQ_EN, 8'h00);
        chk({7'h00, o_irq}, 8'h00);
        wr(tmrps_pkg::ADDR_IRQ_EN, 8'h01);
        wr(tmrps_pkg::ADDR_IRQ_CLR, 8'h01);
        chk({7'h00, o_irq}, 8'h00);
        rd(tmrps_pkg::ADDR_IRQ_CLR);
        chk(rd_v, 8'h00);
        i_sleep <= 1'b0;
        $display("test done: interrupts");
        // about four ticks expected at every ratio
        for (int s = 0; s < 8; s++) begin
            wr(tmrps_pkg::ADDR_OPTION, 8'(s));
            wr(tmrps_pkg::ADDR_COUNT, 8'h00);
            repeat (4 << (s + 1)) @(posedge i_clk);
            #1 rd(tmrps_pkg::ADDR_COUNT);
            chk({7'h00, (rd_v >= 8'h03) && (rd_v <= 8'h05)}, 8'h01);
        end
        $display("test done: prescaler ratios");
        for (int p = 0; p < 2; p++) begin
            wr(tmrps_pkg::ADDR_OPTION, p ? 8'h00 : 8'h08);
            wdt_cnt = 0;
            repeat (4) begin
                i_wdt_tick <= 1'b1;
                @(posedge i_clk);
                #1 i_wdt_tick <= 1'b0;
                repeat (3) @(posedge i_clk);
                #1;
            end
            chk(8'(wdt_cnt), p ? 8'h04 : 8'h02);
        end
        $display("test done: prescaler routing");
        // five toggles give three counting edges of the chosen kind
        for (int e = 0; e < 2; e++) begin
            wr(tmrps_pkg::ADDR_OPTION, e ? 8'h38 : 8'h28);
            wr(tmrps_pkg::ADDR_COUNT, 8'h00);
            burst(8'h05, e ? 8'h5d : 8'h1b);
            repeat (8) @(posedge i_clk);
            #1 rd(tmrps_pkg::ADDR_COUNT);
            chk(rd_v, 8'h03);
        end
        $display("test done: counter mode");
        stop_test();
    end
endmodule
`default_nettype wire
